//--- shared/cpw_pkg.sv
// constants and carriers of the command write-protection block
// assumes a frame decoder that hands over command writes byte by byte
// Function
// - writability per command bit; reads always allowed
// - unwritable command needs password raising level first
// - user and default stores keep own maps, passwords
// - default-cleared bit needs default private password
// - user-cleared bit needs user or default private password
// - four levels; 0-1 public, 2-3 private password
// - private password write never lowers the level
// - any public password write gives level 1/0
// - level byte read-only, not protectable, resets 01h
// - default-cleared bit writable only at level 3
// - user-cleared bit writable only at level 2+
// - level 1 allows bits set in both stores
// - default-store public password is never compared
// - level 0 allows only always-writable commands
// - 256-bit map, code 00h at byte0 bit0
// - every command code owns a map bit
// - default map needs level 3, user level 2
// - map not protectable, resets to all ones
// - public password four bytes, resets to zero
// - hard-default reload sets level 1
package cpw_pkg;
	// ----------------------------------------
	// command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_TIER = 8'hFA;
	localparam logic [7:0] CMD_PRIV = 8'hFB;
	localparam logic [7:0] CMD_KEY  = 8'hFC;
	localparam logic [7:0] CMD_MAP  = 8'hFD;
	// ----------------------------------------
	// access levels and sizes
	// ----------------------------------------
	localparam logic [1:0] LVL0 = 2'h0;
	localparam logic [1:0] LVL1 = 2'h1;
	localparam logic [1:0] LVL2 = 2'h2;
	localparam logic [1:0] LVL3 = 2'h3;
	localparam int MAP_BYTES = 32;
	localparam int KEY_BYTES = 4;
	localparam logic [5:0] KEY_CNT  = 6'h04;
	localparam logic [5:0] MAP_CNT  = 6'h20;
	localparam logic [5:0] CNT_MAX  = 6'h3F;
	localparam logic [7:0] MAP_FILL = 8'hFF;
	localparam logic [31:0] KEY_RST = 32'h00000000;
	localparam logic [5:0] TIER_PAD = 6'h00;
	localparam logic [7:0] RD_ZERO  = 8'h00;
	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic       start;
		logic [7:0] code;
		logic       dvalid;
		logic [7:0] data;
		logic       stop;
	} cpw_frame_t;
	typedef struct packed {
		logic       valid;
		logic [7:0] code;
		logic [7:0] data;
	} cpw_pass_t;
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_LOOK = 2'b01,
		S_TAKE = 2'b11,
		S_READ = 2'b10
	} cpw_state_t;
endpackage : cpw_pkg

//--- hdl/cpw_permit_mem.sv
// two permit-map stores, user and default, one byte per word
// assumes one write and one read address per cycle; read data registered
`timescale 1ns/1ps
module cpw_permit_mem #(
	parameter int DEPTH = 32
) (
	// clock and control
	input  wire logic                     clk,
	input  wire logic                     reset,
	input  wire logic                     ce,
	// write port
	input  wire logic                     we,
	input  wire logic                     wsel_dflt,
	input  wire logic [$clog2(DEPTH)-1:0] waddr,
	input  wire logic [7:0]               wdata,
	// read port, both stores at once
	input  wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic      [7:0]               rd_user,
	output logic      [7:0]               rd_dflt
);
	import cpw_pkg::*;

	logic [7:0] user_q [DEPTH];
	logic [7:0] dflt_q [DEPTH];

	// byte k holds codes 8k..8k+7, lowest code in bit 0
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < DEPTH; i++) begin
				user_q[i] <= MAP_FILL; // all unprotected
				dflt_q[i] <= MAP_FILL;
			end
		end else if (ce && we) begin
			if (wsel_dflt) begin
				dflt_q[waddr] <= wdata; // separate stores
			end else begin
				user_q[waddr] <= wdata;
			end
		end
	end

	// registered read of both stores
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_user <= MAP_FILL;
			rd_dflt <= MAP_FILL;
		end else if (ce) begin
			rd_user <= user_q[raddr];
			rd_dflt <= dflt_q[raddr];
		end
	end
endmodule : cpw_permit_mem

//--- hdl/cpw_write_guard.sv
// access-level keeper and write gate for protected commands
// assumes frames come from a bus decoder, bytes no sooner than 2 cycles
// after start, and private passwords are held by the store logic outside
`timescale 1ns/1ps
module cpw_write_guard #(
	parameter int MAP_DEPTH = 32
) (
	// clock and control
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              ce,
	// command write frame from the bus decoder
	input  wire cpw_pkg::cpw_frame_t frm,
	input  wire logic              map_dflt,
	// command read request
	input  wire logic              rd_req,
	input  wire logic [7:0]        rd_code,
	input  wire logic [4:0]        rd_idx,
	input  wire logic              rd_dflt,
	// private passwords of both stores and reload event
	input  wire logic [31:0]       priv_user,
	input  wire logic [31:0]       priv_dflt,
	input  wire logic              restore,
	// gated parameter bytes and results
	output cpw_pkg::cpw_pass_t     pass_q,
	output logic                   deny_q,
	output logic                   rd_ack_q,
	output logic                   rd_hit_q,
	output logic [7:0]             rd_data_q,
	output logic [7:0]             tier_q,
	output logic                   busy_q
);
	import cpw_pkg::*;

	localparam int AW = $clog2(MAP_DEPTH);

	cpw_state_t  st_q;
	logic [7:0]  code_q;
	logic [5:0]  cnt_q;
	logic [31:0] buf_q;
	logic [1:0]  lvl_q;
	logic [31:0] key_q;
	logic        allow_q;
	logic        sel_q;
	logic [4:0]  idx_q;
	logic [7:0]  mu;
	logic [7:0]  md;
	logic        mem_we;
	logic        map_ok;
	logic        bit_u;
	logic        bit_d;
	logic [AW-1:0] raddr;
	logic        take_byte;
	logic        take_stop;

	// ----------------------------------------
	// helper functions
	// ----------------------------------------
	// decide if a command may change at a level
	function automatic logic wr_ok(input logic [7:0] c, input logic ub,
			input logic db, input logic [1:0] lv);
		logic r;
		r = 1'b0;
		if (c == CMD_TIER) begin
			r = 1'b0; // level byte is read only
		end else if (c == CMD_KEY || c == CMD_PRIV || c == CMD_MAP) begin
			r = 1'b1; // always writable, map guarded per store
		end else if (lv == LVL3) begin
			r = 1'b1;
		end else if (lv == LVL2) begin
			r = db; // default-cleared waits for level 3
		end else if (lv == LVL1) begin
			r = db & ub; // both stores must permit
		end
		return r;
	endfunction : wr_ok

	// level reached by a private password; never lower
	function automatic logic [1:0] raise(input logic [1:0] lv,
			input logic [1:0] want);
		return (want > lv) ? want : lv;
	endfunction : raise

	// ----------------------------------------
	// permit map storage
	// ----------------------------------------
	// default map wants level 3, user map level 2
	assign map_ok = sel_q ? (lvl_q == LVL3) : (lvl_q >= LVL2);
	assign take_byte = ce && st_q == S_TAKE && frm.dvalid;
	assign take_stop = ce && st_q == S_TAKE && frm.stop;
	assign mem_we = take_byte && code_q == CMD_MAP && map_ok
		&& cnt_q < MAP_CNT;
	// read address: map byte of the command code or the host index
	always_comb begin
		raddr = rd_idx[AW-1:0];
		if (frm.start) begin
			raddr = frm.code[7:3]; // byte that holds the code's bit
		end
	end
	assign bit_u = mu[code_q[2:0]];
	assign bit_d = md[code_q[2:0]];

	cpw_permit_mem #(
		.DEPTH(MAP_DEPTH)
	) u_mem (
		.clk      (clk),
		.reset    (reset),
		.ce       (ce),
		.we       (mem_we),
		.wsel_dflt(sel_q),
		.waddr    (cnt_q[AW-1:0]),
		.wdata    (frm.data),
		.raddr    (raddr),
		.rd_user  (mu),
		.rd_dflt  (md)
	);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// a start wins over a read request in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			st_q <= S_IDLE;
		end else if (ce) begin
			case (st_q)
				S_IDLE: begin
					if (frm.start) begin
						st_q <= S_LOOK;
					end else if (rd_req) begin
						st_q <= S_READ;
					end
				end
				S_LOOK: begin
					st_q <= S_TAKE;
				end
				S_TAKE: begin
					if (frm.stop) begin
						st_q <= S_IDLE;
					end
				end
				S_READ: begin
					st_q <= S_IDLE;
				end
				default: begin
					st_q <= S_IDLE;
				end
			endcase
		end
	end

	// capture code, store select and read index
	always_ff @(posedge clk) begin
		if (reset) begin
			code_q <= RD_ZERO;
			sel_q  <= 1'b0;
			idx_q  <= 5'h00;
		end else if (ce && st_q == S_IDLE) begin
			if (frm.start) begin
				code_q <= frm.code;
				sel_q  <= map_dflt;
			end else if (rd_req) begin
				code_q <= rd_code;
				sel_q  <= rd_dflt;
				idx_q  <= rd_idx;
			end
		end
	end

	// busy while a frame or a read is in flight
	always_ff @(posedge clk) begin
		if (reset) begin
			busy_q <= 1'b0;
		end else if (ce) begin
			busy_q <= (st_q == S_IDLE) ? (frm.start || rd_req)
				: !(st_q == S_READ || (st_q == S_TAKE && frm.stop));
		end
	end

	// ----------------------------------------
	// write decision
	// ----------------------------------------
	// one decision per frame, held until its stop
	always_ff @(posedge clk) begin
		if (reset) begin
			allow_q <= 1'b0;
		end else if (ce && st_q == S_LOOK) begin
			allow_q <= wr_ok(code_q, bit_u, bit_d, lvl_q);
		end
	end

	// byte counter and password assembly, first byte lowest
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q <= 6'h00;
			buf_q <= KEY_RST;
		end else if (ce && st_q == S_LOOK) begin
			cnt_q <= 6'h00;
			buf_q <= KEY_RST;
		end else if (take_byte) begin
			if (cnt_q < KEY_CNT) begin
				buf_q[cnt_q[1:0]*8 +: 8] <= frm.data;
			end
			if (cnt_q != CNT_MAX) begin
				cnt_q <= cnt_q + 6'h01;
			end
		end
	end

	// forward parameter bytes only when allowed
	always_ff @(posedge clk) begin
		if (reset) begin
			pass_q <= '0;
		end else if (ce) begin
			pass_q.valid <= take_byte && allow_q && code_q != CMD_KEY
				&& code_q != CMD_PRIV && code_q != CMD_MAP;
			pass_q.code  <= code_q;
			pass_q.data  <= frm.data;
		end
	end

	// refused frame reported at its stop
	always_ff @(posedge clk) begin
		if (reset) begin
			deny_q <= 1'b0;
		end else if (ce) begin
			deny_q <= take_stop && (!allow_q
				|| (code_q == CMD_MAP && !map_ok));
		end
	end

	// ----------------------------------------
	// access level and shared key
	// ----------------------------------------
	// four levels; reload to level 1 wins over a password
	always_ff @(posedge clk) begin
		if (reset) begin
			lvl_q <= LVL1;
		end else if (ce && restore) begin
			lvl_q <= LVL1;
		end else if (take_stop && code_q == CMD_KEY) begin
			// only the user-store key is compared
			lvl_q <= (cnt_q == KEY_CNT && buf_q == key_q) ? LVL1 : LVL0;
		end else if (take_stop && code_q == CMD_PRIV && cnt_q == KEY_CNT) begin
			if (buf_q == priv_dflt) begin
				lvl_q <= raise(lvl_q, LVL3);
			end else if (buf_q == priv_user) begin
				lvl_q <= raise(lvl_q, LVL2);
			end
		end
	end

	// the key changes only from level 2 so a guess cannot rewrite it
	always_ff @(posedge clk) begin
		if (reset) begin
			key_q <= KEY_RST;
		end else if (take_stop && code_q == CMD_KEY && cnt_q == KEY_CNT
				&& lvl_q >= LVL2) begin
			key_q <= buf_q;
		end
	end

	// level byte mirrors the level register
	always_ff @(posedge clk) begin
		if (reset) begin
			tier_q <= {TIER_PAD, LVL1};
		end else if (ce) begin
			tier_q <= {TIER_PAD, lvl_q};
		end
	end

	// ----------------------------------------
	// read path, never gated by protection
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_ack_q  <= 1'b0;
			rd_hit_q  <= 1'b0;
			rd_data_q <= RD_ZERO;
		end else if (ce) begin
			rd_ack_q <= st_q == S_READ;
			if (st_q == S_READ) begin
				rd_hit_q <= 1'b1;
				case (code_q)
					CMD_TIER: rd_data_q <= {TIER_PAD, lvl_q};
					CMD_KEY: begin
						rd_data_q <= (idx_q < KEY_BYTES)
							? key_q[idx_q[1:0]*8 +: 8] : RD_ZERO;
					end
					CMD_MAP: rd_data_q <= sel_q ? md : mu;
					default: begin
						rd_hit_q  <= 1'b0; // served elsewhere
						rd_data_q <= RD_ZERO;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_pass_gated: assert property (pass_q.valid |-> allow_q)
		else $error("parameter byte forwarded without permission");
	a_key_level: assert property (take_stop && code_q == CMD_KEY
			&& !restore |=> lvl_q <= LVL1)
		else $error("public password left level above 1");
	a_priv_keep: assert property (take_stop && code_q == CMD_PRIV
			&& !restore |=> lvl_q >= $past(lvl_q))
		else $error("private password lowered level");
	a_reload_lvl: assert property (ce && restore |=> lvl_q == LVL1)
		else $error("reload did not set level 1");
	a_reset_vals: assert property ($past(reset) |-> tier_q == 8'h01
			&& key_q == KEY_RST)
		else $error("reset values wrong");
	a_map_guard: assert property (mem_we |-> (sel_q ? lvl_q == LVL3
			: lvl_q >= LVL2))
		else $error("map written at low level");
	a_dflt_lock: assert property (ce && st_q == S_LOOK && !bit_d
			&& lvl_q != LVL3 && code_q < CMD_TIER |=> !allow_q)
		else $error("default-protected command allowed");
	a_both_open: assert property (ce && st_q == S_LOOK && bit_d && bit_u
			&& lvl_q != LVL0 && code_q != CMD_TIER |=> allow_q)
		else $error("open command refused at level 1");
	a_read_ack: assert property (ce && st_q == S_IDLE && rd_req
			&& !frm.start ##1 ce |=> rd_ack_q)
		else $error("read not answered");
endmodule : cpw_write_guard

//--- tb/cpw_host_model.sv
// bus host model: issues command write frames and byte reads
// assumes the guard's frame and read timing; the bench calls its tasks
`timescale 1ns/1ps
module cpw_host_model (
	// clock
	input  wire logic           clk,
	// requests towards the guard
	output cpw_pkg::cpw_frame_t frm,
	output logic                map_dflt,
	output logic                rd_req,
	output logic [7:0]          rd_code,
	output logic [4:0]          rd_idx,
	output logic                rd_dflt,
	// read answer
	input  wire logic           rd_ack_q,
	input  wire logic [7:0]     rd_data_q
);
	import cpw_pkg::*;
	// idle bus at time zero
	initial begin
		frm = '0;
		map_dflt = 1'b0;
		rd_req = 1'b0;
		rd_code = 8'h00;
		rd_idx = 5'h00;
		rd_dflt = 1'b0;
	end
	// write frame; a refused command needs a password frame first
	task automatic send(input logic [7:0] c, input logic d, input logic [31:0] v, input int n);
		@(posedge clk);
		frm.start <= 1'b1;
		frm.code <= c;
		map_dflt <= d;
		@(posedge clk);
		frm.start <= 1'b0;
		@(posedge clk);
		for (int k = 0; k < n; k++) begin
			frm.dvalid <= 1'b1;
			frm.data <= v[8*k+:8];
			@(posedge clk);
		end
		frm.dvalid <= 1'b0;
		frm.data <= ~v[8*(n-1)+:8]; // released bus must not show the last byte
		frm.stop <= 1'b1;
		@(posedge clk);
		frm.stop <= 1'b0;
		frm.code <= ~c;
	endtask : send
	// one byte read, address held until the answer
	task automatic read(input logic [7:0] c, input logic [4:0] i, input logic d,
		output logic [7:0] q, output logic ok);
		ok = 1'b0;
		@(posedge clk);
		rd_req <= 1'b1;
		rd_code <= c;
		rd_idx <= i;
		rd_dflt <= d;
		@(posedge clk);
		rd_req <= 1'b0;
		for (int k = 0; k < 8 && !ok; k++) begin
			@(posedge clk);
			ok = (rd_ack_q === 1'b1);
		end
		q = rd_data_q;
		rd_code <= ~c;
		rd_idx <= ~i;
	endtask : read
endmodule : cpw_host_model

//--- tb/tb_top.sv
// self-checking bench of the command write guard
// assumes ce stays high outside the reload scenario and both private passwords are fixed
`timescale 1ns/1ps
module tb_top;
	import cpw_pkg::*;
	localparam logic [31:0] PW_USER = 32'h55AA3C11;
	localparam logic [31:0] PW_DFLT = 32'h0F1E2D4B;
	logic       clk, reset, ce, restore, map_dflt, rd_req, rd_dflt;
	logic       deny_q, rd_ack_q, rd_hit_q, busy_q;
	logic [7:0] rd_code, rd_data_q, tier_q, pass_data, pass_code;
	logic [4:0] rd_idx;
	cpw_frame_t frm;
	cpw_pass_t  pass_q;
	int         failures, check_count, pass_cnt, deny_cnt;
	// ----------------------------------------
	// clock, host and design
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	cpw_host_model host (.clk(clk), .frm(frm), .map_dflt(map_dflt), .rd_req(rd_req),
		.rd_code(rd_code), .rd_idx(rd_idx), .rd_dflt(rd_dflt), .rd_ack_q(rd_ack_q),
		.rd_data_q(rd_data_q));
	cpw_write_guard DUT (.clk(clk), .reset(reset), .ce(ce), .frm(frm), .map_dflt(map_dflt),
		.rd_req(rd_req), .rd_code(rd_code), .rd_idx(rd_idx), .rd_dflt(rd_dflt),
		.priv_user(PW_USER), .priv_dflt(PW_DFLT), .restore(restore), .pass_q(pass_q),
		.deny_q(deny_q), .rd_ack_q(rd_ack_q), .rd_hit_q(rd_hit_q), .rd_data_q(rd_data_q),
		.tier_q(tier_q), .busy_q(busy_q));
	// count one-cycle results as they stand
	always @(posedge clk) begin
		if (pass_q.valid === 1'b1) begin
			pass_cnt++;
			pass_data = pass_q.data;
			pass_code = pass_q.code;
		end
		if (deny_q === 1'b1)
			deny_cnt++;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	// frame then results; -1 skips a count the contract leaves open
	task automatic frame(input logic [7:0] c, input logic d, input logic [31:0] v,
		input int n, input int np, input int nd, input logic [1:0] lv);
		pass_cnt = 0;
		deny_cnt = 0;
		host.send(c, d, v, n);
		repeat (3) @(posedge clk);
		if (np >= 0)
			chk("pass count", 8'(np), 8'(pass_cnt));
		if (nd >= 0)
			chk("deny count", 8'(nd), 8'(deny_cnt));
		chk("tier", {TIER_PAD, lv}, tier_q);
		chk("busy", 8'h00, {7'h00, busy_q});
	endtask : frame
	task automatic rd(input logic [7:0] c, input logic [4:0] i, input logic d,
		input logic [7:0] exp);
		logic [7:0] q;
		logic       ok;
		host.read(c, i, d, q, ok);
		if (ok !== 1'b1) begin
			failures++;
			report_and_stop();
		end
		chk("read data", exp, q);
	endtask : rd
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(CMD_TIER, 5'h00, 1'b0, 8'h01);
		chk("read hit", 8'h01, {7'h00, rd_hit_q});
		rd(8'h01, 5'h00, 1'b0, RD_ZERO);
		chk("read hit", 8'h00, {7'h00, rd_hit_q});
		rd(CMD_KEY, 5'h03, 1'b0, 8'h00);
		rd(CMD_MAP, 5'h00, 1'b0, MAP_FILL);
		rd(CMD_MAP, 5'h1F, 1'b1, MAP_FILL);
	endtask : t_reset
	task automatic t_public();
		frame(CMD_KEY, 1'b0, 32'h01020304, 4, -1, -1, LVL0);
		frame(8'h01, 1'b0, 32'h5A, 1, 0, 1, LVL0);
		rd(CMD_MAP, 5'h00, 1'b0, MAP_FILL);
		rd(CMD_TIER, 5'h00, 1'b0, 8'h00);
		frame(CMD_KEY, 1'b0, KEY_RST, 4, -1, -1, LVL1);
		frame(8'h01, 1'b0, 32'h5A, 1, 1, 0, LVL1);
		chk("pass data", 8'h5A, pass_data);
		chk("pass code", 8'h01, pass_code);
	endtask : t_public
	task automatic t_private();
		frame(CMD_PRIV, 1'b0, PW_USER, 3, -1, -1, LVL1);
		frame(CMD_PRIV, 1'b0, PW_USER, 4, -1, -1, LVL2);
		frame(CMD_PRIV, 1'b0, 32'h0, 4, -1, -1, LVL2);
		frame(CMD_PRIV, 1'b0, PW_DFLT, 4, -1, -1, LVL3);
		frame(CMD_PRIV, 1'b0, PW_USER, 4, -1, -1, LVL3);
		frame(CMD_KEY, 1'b0, KEY_RST, 4, -1, -1, LVL1);
	endtask : t_private
	task automatic t_user_map();
		frame(CMD_MAP, 1'b0, 32'hFE, 1, -1, 1, LVL1);
		rd(CMD_MAP, 5'h00, 1'b0, MAP_FILL);
		frame(CMD_PRIV, 1'b0, PW_USER, 4, -1, -1, LVL2);
		frame(CMD_MAP, 1'b0, 32'hFE, 1, -1, 0, LVL2);
		rd(CMD_MAP, 5'h00, 1'b0, 8'hFE);
		frame(CMD_MAP, 1'b1, 32'hFDFF, 2, -1, 1, LVL2);
		rd(CMD_MAP, 5'h01, 1'b1, MAP_FILL);
		frame(8'h00, 1'b0, 32'hA5, 1, 1, 0, LVL2);
		chk("pass data", 8'hA5, pass_data);
		frame(CMD_KEY, 1'b0, KEY_RST, 4, -1, -1, LVL1);
		frame(8'h00, 1'b0, 32'hA5, 1, 0, 1, LVL1);
	endtask : t_user_map
	task automatic t_dflt_map();
		frame(CMD_PRIV, 1'b0, PW_DFLT, 4, -1, -1, LVL3);
		frame(CMD_MAP, 1'b1, 32'hFDFF, 2, -1, 0, LVL3);
		rd(CMD_MAP, 5'h01, 1'b1, 8'hFD);
		rd(CMD_MAP, 5'h01, 1'b0, MAP_FILL);
		frame(CMD_TIER, 1'b0, 32'h02, 1, 0, 1, LVL3);
		frame(CMD_KEY, 1'b0, KEY_RST, 4, -1, -1, LVL1);
		frame(CMD_PRIV, 1'b0, PW_USER, 4, -1, -1, LVL2);
		frame(8'h09, 1'b0, 32'h3C, 1, 0, 1, LVL2);
		frame(8'h08, 1'b0, 32'h3C, 1, 1, 0, LVL2);
		frame(CMD_PRIV, 1'b0, PW_DFLT, 4, -1, -1, LVL3);
		frame(8'h09, 1'b0, 32'h3C, 1, 1, 0, LVL3);
		chk("pass code", 8'h09, pass_code);
	endtask : t_dflt_map
	task automatic t_restore();
		// a reload while the clock enable is low must not touch the level
		@(posedge clk);
		ce <= 1'b0;
		restore <= 1'b1;
		repeat (2) @(posedge clk);
		restore <= 1'b0;
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		chk("tier while frozen", {TIER_PAD, LVL3}, tier_q);
		@(posedge clk);
		restore <= 1'b1;
		@(posedge clk);
		restore <= 1'b0;
		repeat (2) @(posedge clk);
		chk("tier after reload", 8'h01, tier_q);
	endtask : t_restore
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		restore = 1'b0;
		failures = 0;
		check_count = 0;
		pass_cnt = 0;
		deny_cnt = 0;
		pass_data = 8'h00;
		pass_code = 8'h00;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_public();
		t_private();
		t_user_map();
		t_dflt_map();
		t_restore();
		report_and_stop();
	end
endmodule : tb_top
